//--- inc/pbcc_pkg.sv
// package: register map, field layout, modes and timing for the port b / capcom pin block
package pbcc_pkg;
   // register byte addresses on the wishbone bus
   localparam logic [15:0] PBCC_ADDR_DATA = 16'hffc0; // port_b_data_latch
   localparam logic [15:0] PBCC_ADDR_DIR = 16'hffc2; // port_b_direction
   localparam logic [15:0] PBCC_ADDR_ODRV = 16'hf1c2; // port2_output_driver_mode
   localparam logic [15:0] PBCC_ADDR_PIN = 16'hf1c4; // input latch, read only
   localparam logic [15:0] PBCC_ADDR_CCMODE = 16'hf1c8; // channel compare enable
   localparam logic [15:0] PBCC_ADDR_CCSEL = 16'hf1cc; // channel compare mode select
   // field layout
   localparam int PBCC_LINE_LO = 2;
   localparam int PBCC_LINE_HI = 15;
   localparam int PBCC_FIRQ_LO = 8;
   localparam int PBCC_T7_LINE = 15;
   localparam logic [15:0] PBCC_LINE_MASK = 16'hfffc; // bits 1 and 0 unimplemented
   // reset values
   localparam logic [15:0] PBCC_RST_REG = 16'h0000;
   // interrupt sample period: 83.34 ns at 48 MHz, i.e. four cpu clocks
   localparam int PBCC_SAMPLE_CLKS = 4;
   localparam logic [1:0] PBCC_SAMPLE_LAST = 2'h3;
   // compare mode encoding per channel
   typedef enum logic [1:0] {
      PBCC_CMP_OFF = 2'h0,
      PBCC_CMP_TOGGLE = 2'h1, // compare mode 1
      PBCC_CMP_SET = 2'h3 // compare mode 3
   } pbcc_cmp_e;
endpackage : pbcc_pkg

//--- design/pbcc_wb_slave.sv
// wishbone classic slave: decode, one-cycle ack, register write strobes and readback
module pbcc_wb_slave
   import pbcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [15:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic [5:0] wr_o,
   output logic [15:0] wdata_o,
   input wire logic [15:0] rd_data_i,
   input wire logic [15:0] rd_dir_i,
   input wire logic [15:0] rd_odrv_i,
   input wire logic [15:0] rd_pin_i,
   input wire logic [15:0] rd_ccen_i,
   input wire logic [15:0] rd_ccsel_i
);
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } pbcc_wb_s;
   pbcc_wb_s st, next_st;
   logic req;
   logic [15:0] rsel;
   logic [5:0] hit;

   // address decode
   always_comb begin
      hit = 6'h00;
      rsel = 16'h0000;
      if (adr_i == PBCC_ADDR_DATA) begin
         hit = 6'h01;
         rsel = rd_data_i;
      end else if (adr_i == PBCC_ADDR_DIR) begin
         hit = 6'h02;
         rsel = rd_dir_i;
      end else if (adr_i == PBCC_ADDR_ODRV) begin
         hit = 6'h04;
         rsel = rd_odrv_i;
      end else if (adr_i == PBCC_ADDR_PIN) begin
         hit = 6'h08;
         rsel = rd_pin_i;
      end else if (adr_i == PBCC_ADDR_CCMODE) begin
         hit = 6'h10;
         rsel = rd_ccen_i;
      end else if (adr_i == PBCC_ADDR_CCSEL) begin
         hit = 6'h20;
         rsel = rd_ccsel_i;
      end
   end

   assign req = cyc_i && stb_i && !st.ack;
   // write strobe only when both low byte lanes are enabled
   assign wr_o = (req && we_i && (sel_i[1:0] == 2'h3)) ? (hit & 6'h37) : 6'h00;
   assign wdata_o = dat_i[15:0];
   assign ack_o = st.ack;
   assign dat_o = st.dat;

   // ack one cycle after request; unmapped reads give zero
   always_comb begin
      next_st = st;
      next_st.ack = req;
      if (req && !we_i) begin
         next_st.dat = {16'h0000, rsel};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : pbcc_wb_slave

//--- design/pbcc_sampler.sv
// interrupt input sampler: pin levels captured once every sample period
module pbcc_sampler
   import pbcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [15:0] level_i,
   output logic [15:0] sample_o,
   output logic tick_o
);
   typedef struct packed {
      logic [1:0] cnt;
      logic [15:0] smp;
   } pbcc_smp_s;
   pbcc_smp_s st, next_st;

   // free running divider; sample taken on its last count
   always_comb begin
      next_st = st;
      next_st.cnt = st.cnt + 2'h1;
      if (st.cnt == PBCC_SAMPLE_LAST) begin
         next_st.smp = level_i & PBCC_LINE_MASK;
      end
   end

   assign sample_o = st.smp;
   assign tick_o = (st.cnt == PBCC_SAMPLE_LAST);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : pbcc_sampler

//--- design/pbcc_port.sv
// port b pin logic shared with capture/compare unit a
// Notes on behaviour
// - open drain bit 0 drives push/pull, bit 1 drives only low.
// - lines 15 to 2 serve as capture input or compare output per channel.
// - capture input takes the input latch, which follows the pin.
// - output lines feed the output latch to capture, allowing software triggers.
// - compare mode 1 match inverts the output latch.
// - compare mode 3 match loads one into the output latch.
// - compare mode 3 timer overflow also acts on the output latch.
// - hardware latch updates happen only on the compare trigger strobe.
// - software may write the output latch while compare uses it.
// - cpu write and compare trigger together: cpu value kept.
// - a cpu write selects the bus path into the latch.
// - bus data and alternate data merge ahead of the latch.
// - capture lines are sampled as external interrupts every 83.34 ns.
// - lines 15 to 8 are fast interrupt inputs 7 to 0.
// - line 15 is the count input of timer seven.
// - direction bit 0 means input, 1 means output.
module pbcc_port
   import pbcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [15:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [15:0] pin_i,
   output logic [15:0] pin_o,
   output logic [15:0] pin_oe_o,
   input wire logic [15:0] cmp_trig_i,
   input wire logic [15:0] cmp_match_i,
   input wire logic [15:0] tovf_i,
   output logic [15:0] cap_o,
   output logic [15:0] ext_irq_o,
   output logic [7:0] fast_irq_o,
   output logic timer_seven_count_o
);
   typedef struct packed {
      logic [15:0] data;
      logic [15:0] dir;
      logic [15:0] odrv;
      logic [15:0] inl;
      logic [15:0] ccen;
      logic [15:0] ccsel;
      logic [15:0] cap;
   } pbcc_port_s;
   pbcc_port_s st, next_st;
   logic [5:0] wr;
   logic [15:0] wdata;
   logic [15:0] alt_do;
   logic [15:0] hw_upd;
   logic [15:0] smp;
   logic tick;

   // compare mode of one channel
   function automatic pbcc_cmp_e chan_mode(input logic en, input logic sel);
      if (!en) begin
         return PBCC_CMP_OFF;
      end
      return sel ? PBCC_CMP_SET : PBCC_CMP_TOGGLE;
   endfunction : chan_mode

   pbcc_wb_slave u_bus (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .adr_i(adr_i),
      .sel_i(sel_i),
      .dat_i(dat_i),
      .dat_o(dat_o),
      .ack_o(ack_o),
      .wr_o(wr),
      .wdata_o(wdata),
      .rd_data_i(st.data),
      .rd_dir_i(st.dir),
      .rd_odrv_i(st.odrv),
      .rd_pin_i(st.inl),
      .rd_ccen_i(st.ccen),
      .rd_ccsel_i(st.ccsel)
   );

   pbcc_sampler u_smp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(st.cap),
      .sample_o(smp),
      .tick_o(tick)
   );

   // alternate data output and which lines the compare trigger may clock
   always_comb begin
      alt_do = st.data;
      hw_upd = 16'h0000;
      for (int i = PBCC_LINE_LO; i <= PBCC_LINE_HI; i++) begin
         case (chan_mode(st.ccen[i], st.ccsel[i]))
            PBCC_CMP_TOGGLE: begin
               alt_do[i] = ~st.data[i];
               hw_upd[i] = cmp_trig_i[i] && cmp_match_i[i];
            end
            PBCC_CMP_SET: begin
               alt_do[i] = 1'b1;
               hw_upd[i] = cmp_trig_i[i] && (cmp_match_i[i] || tovf_i[i]);
            end
            default: begin
               alt_do[i] = st.data[i];
            end
         endcase
      end
   end

   // register and latch updates; cpu write path wins over alternate path
   always_comb begin
      next_st = st;
      for (int i = PBCC_LINE_LO; i <= PBCC_LINE_HI; i++) begin
         if (wr[0]) begin
            next_st.data[i] = wdata[i];
         end else if (hw_upd[i]) begin
            next_st.data[i] = alt_do[i];
         end
      end
      if (wr[1]) next_st.dir = wdata & PBCC_LINE_MASK;
      if (wr[2]) next_st.odrv = wdata & PBCC_LINE_MASK;
      if (wr[4]) next_st.ccen = wdata & PBCC_LINE_MASK;
      if (wr[5]) next_st.ccsel = wdata & PBCC_LINE_MASK;
      next_st.inl = pin_i & PBCC_LINE_MASK;
      // capture source: pin via input latch, or output latch on outputs
      next_st.cap = ((st.dir & st.data) | (~st.dir & st.inl)) & PBCC_LINE_MASK;
   end

   // pin drivers: direction gates enable, open drain drives only low
   always_comb begin
      pin_o = st.data;
      pin_oe_o = st.dir & ~(st.odrv & st.data);
   end

   assign cap_o = st.cap;
   assign ext_irq_o = smp;
   assign fast_irq_o = smp[PBCC_LINE_HI:PBCC_FIRQ_LO];
   assign timer_seven_count_o = st.inl[PBCC_T7_LINE];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // cpu write beats compare trigger
   property p_cpu_wins;
      @(posedge clk_i) disable iff (rst_i)
      (wr[0] && hw_upd[2]) |=> (st.data[2] == $past(wdata[2]));
   endproperty
   a_cpu_wins: assert property (p_cpu_wins) else $error("cpu write lost");

   property p_toggle;
      @(posedge clk_i) disable iff (rst_i)
      (!wr[0] && hw_upd[3] && st.ccen[3] && !st.ccsel[3]) |=> (st.data[3] != $past(st.data[3]));
   endproperty
   a_toggle: assert property (p_toggle) else $error("mode 1 no toggle");

   property p_set;
      @(posedge clk_i) disable iff (rst_i)
      (!wr[0] && hw_upd[4] && st.ccen[4] && st.ccsel[4]) |=> st.data[4];
   endproperty
   a_set: assert property (p_set) else $error("mode 3 no set");

   property p_strobe;
      @(posedge clk_i) disable iff (rst_i)
      (!wr[0] && !cmp_trig_i[5]) |=> $stable(st.data[5]);
   endproperty
   a_strobe: assert property (p_strobe) else $error("latch moved without trigger");

   property p_opendrain;
      @(posedge clk_i) disable iff (rst_i)
      (st.odrv[6] && st.data[6]) |-> !pin_oe_o[6];
   endproperty
   a_opendrain: assert property (p_opendrain) else $error("open drain drove high");

   property p_dir_in;
      @(posedge clk_i) disable iff (rst_i)
      !st.dir[7] |-> !pin_oe_o[7];
   endproperty
   a_dir_in: assert property (p_dir_in) else $error("input line driven");

   sequence s_pin_high;
      !st.dir[8] && pin_i[8];
   endsequence
   property p_cap_pin;
      @(posedge clk_i) disable iff (rst_i)
      s_pin_high ##1 !st.dir[8] |=> cap_o[8];
   endproperty
   a_cap_pin: assert property (p_cap_pin) else $error("capture missed pin");

   property p_unimpl;
      @(posedge clk_i) disable iff (rst_i)
      (st.odrv[1:0] == 2'h0) && (cap_o[1:0] == 2'h0);
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("low bits set");

   property p_fast;
      @(posedge clk_i) disable iff (rst_i)
      tick |=> (fast_irq_o == ($past(st.cap[15:8])));
   endproperty
   a_fast: assert property (p_fast) else $error("fast irq sample wrong");

   // input latch follows the pad one clock later
   property p_in_latch;
      @(posedge clk_i) disable iff (rst_i)
      !rst_i |=> (st.inl[12] == $past(pin_i[12]));
   endproperty
   a_in_latch: assert property (p_in_latch) else $error("input latch lost pad");

   // output line feeds its own latch to the capture logic
   property p_cap_out;
      @(posedge clk_i) disable iff (rst_i)
      st.dir[9] |=> (cap_o[9] == $past(st.data[9]));
   endproperty
   a_cap_out: assert property (p_cap_out) else $error("capture ignored latch");

   // software write to an output line reaches the capture logic two clocks later
   sequence s_out_write;
      st.dir[10] && wr[0];
   endsequence
   property p_sw_capture;
      @(posedge clk_i) disable iff (rst_i)
      s_out_write ##1 st.dir[10] |=> (cap_o[10] == $past(wdata[10], 2));
   endproperty
   a_sw_capture: assert property (p_sw_capture) else $error("sw capture missed");

   // a channel outside compare mode never moves the latch by itself
   property p_mode_off;
      @(posedge clk_i) disable iff (rst_i)
      (!wr[0] && !st.ccen[12]) |=> $stable(st.data[12]);
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("idle channel moved");

   // mode 3 overflow alone sets the latch
   property p_ovf_set;
      @(posedge clk_i) disable iff (rst_i)
      (!wr[0] && cmp_trig_i[5] && tovf_i[5] && st.ccen[5] && st.ccsel[5]) |=> st.data[5];
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow did not set");

   // mode 1 needs a real match to toggle; overflow alone does nothing
   property p_tog_match;
      @(posedge clk_i) disable iff (rst_i)
      (!wr[0] && !cmp_match_i[6] && st.ccen[6] && !st.ccsel[6]) |=> $stable(st.data[6]);
   endproperty
   a_tog_match: assert property (p_tog_match) else $error("toggle without match");

   // a cpu write always lands, compare channel or not
   property p_cpu_write;
      @(posedge clk_i) disable iff (rst_i)
      wr[0] |=> (st.data[9] == $past(wdata[9]));
   endproperty
   a_cpu_write: assert property (p_cpu_write) else $error("cpu write lost");

   // hardware update takes the alternate data path
   property p_alt_path;
      @(posedge clk_i) disable iff (rst_i)
      (!wr[0] && hw_upd[10]) |=> (st.data[10] == $past(alt_do[10]));
   endproperty
   a_alt_path: assert property (p_alt_path) else $error("alternate data lost");

   // push/pull output line always drives
   property p_dir_out;
      @(posedge clk_i) disable iff (rst_i)
      (st.dir[9] && !st.odrv[9]) |-> pin_oe_o[9];
   endproperty
   a_dir_out: assert property (p_dir_out) else $error("output line not driven");

   // open drain line still pulls low
   property p_od_low;
      @(posedge clk_i) disable iff (rst_i)
      (st.dir[7] && st.odrv[7] && !st.data[7]) |-> pin_oe_o[7];
   endproperty
   a_od_low: assert property (p_od_low) else $error("open drain low not driven");

   // external interrupt sample taken once every four clocks
   sequence s_gap;
      !tick [*3];
   endsequence
   property p_period;
      @(posedge clk_i) disable iff (rst_i)
      tick |=> s_gap ##1 tick;
   endproperty
   a_period: assert property (p_period) else $error("sample period wrong");

   // sampled interrupt lines hold between sample points
   property p_sample_hold;
      @(posedge clk_i) disable iff (rst_i)
      !tick |=> $stable(ext_irq_o);
   endproperty
   a_sample_hold: assert property (p_sample_hold) else $error("irq moved off tick");

   // timer seven count input follows line 15
   property p_t7;
      @(posedge clk_i) disable iff (rst_i)
      !rst_i |=> (timer_seven_count_o == $past(pin_i[15]));
   endproperty
   a_t7: assert property (p_t7) else $error("timer count input wrong");
endmodule : pbcc_port

//--- dv/pbcc_pin_model.sv
// far side model: pad wires with pull-ups and an optional external driver
module pbcc_pin_model
   import pbcc_pkg::*;
(
   input wire logic [15:0] pad_out_i,
   input wire logic [15:0] pad_oe_i,
   input wire logic [15:0] ext_en_i,
   input wire logic [15:0] ext_val_i,
   output logic [15:0] pad_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // outside driver steps back wherever the port drives; released lines float high
   always_comb begin
      for (int b = 0; b < 16; b++) begin
         if (pad_oe_i[b]) begin
            pad_in_o[b] = pad_out_i[b];
         end else if (ext_en_i[b]) begin
            pad_in_o[b] = ext_val_i[b];
         end else begin
            pad_in_o[b] = 1'b1;
         end
      end
   end
endmodule : pbcc_pin_model

//--- dv/port2_capcom_pin_logic_tb_top.sv
// self-checking bench for the port b / capcom pin block
module port2_capcom_pin_logic_tb_top
   import pbcc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] e;} pbcc_row_s;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [15:0] adr = 16'h0000, pin_i, pin_o, pin_oe, trig = 16'h0000, match = 16'h0000;
   logic [15:0] tovf = 16'h0000, cap, irq, ext_en = 16'h0000, ext_val = 16'h0000, q;
   logic [31:0] dat = 32'h0, dat_o;
   logic [7:0] fast;
   logic t7;
   int err_count = 0, n_compared = 0, cyc_cnt = 0;
   pbcc_row_s rows[5] = '{'{PBCC_ADDR_ODRV, 16'hffff, 16'hfffc}, '{PBCC_ADDR_DIR, 16'h0003,
      16'h0000}, '{PBCC_ADDR_DATA, 16'hffff, 16'hfffc}, '{PBCC_ADDR_CCMODE, 16'h0ffc, 16'h0ffc},
      '{16'h0100, 16'h1234, 16'h0000}};
   pbcc_port dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_o(pin_oe), .cmp_trig_i(trig), .cmp_match_i(match),
      .tovf_i(tovf), .cap_o(cap), .ext_irq_o(irq), .fast_irq_o(fast),
      .timer_seven_count_o(t7));
   pbcc_pin_model pads (.pad_out_i(pin_o), .pad_oe_i(pin_oe), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pad_in_o(pin_i));
   // clock and hang guard
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         err_count++;
         conclude();
      end
   end
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   // one classic cycle; t pulses trigger and match with the request edge
   // request held until ack is seen; only the bench timeout ends a hung wait
   task wb(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [15:0] t);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {16'h0000, d};
      trig <= t;
      match <= t;
      do begin
         @(posedge clk_i);
         trig <= 16'h0000;
         match <= 16'h0000;
      end while (ack !== 1'b1);
      q = dat_o[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task cmp(input logic [15:0] t, input logic [15:0] m, input logic [15:0] o);
      @(posedge clk_i);
      trig <= t; match <= m; tovf <= o;
      @(posedge clk_i);
      trig <= 16'h0000; match <= 16'h0000; tovf <= 16'h0000;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : cmp
   task conclude();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, PBCC_ADDR_ODRV, 16'h0000, 16'h0000);
      chk(q, PBCC_RST_REG);
      chk(pin_oe, 16'h0000);
      foreach (rows[i]) begin
         wb(1'b1, rows[i].a, rows[i].d, 16'h0000);
         wb(1'b0, rows[i].a, 16'h0000, 16'h0000);
         chk(q, rows[i].e);
      end
      $display("register table done");
      wb(1'b1, PBCC_ADDR_DIR, 16'hfffc, 16'h0000);
      wb(1'b1, PBCC_ADDR_DATA, 16'h0030, 16'h0000);
      wb(1'b1, PBCC_ADDR_ODRV, 16'h00f0, 16'h0000);
      #1 chk(pin_oe, 16'hffcc);
      wb(1'b1, PBCC_ADDR_ODRV, 16'h0000, 16'h0000);
      // lines turned to input before anything outside drives them
      wb(1'b1, PBCC_ADDR_DIR, 16'h0000, 16'h0000);
      ext_val <= 16'ha5a4;
      ext_en <= 16'hffff;
      repeat (10) @(posedge clk_i);
      #1 chk(pin_oe, 16'h0000);
      chk(cap & PBCC_LINE_MASK, 16'ha5a4);
      chk(irq & PBCC_LINE_MASK, 16'ha5a4);
      chk({8'h00, fast}, 16'h00a5);
      chk({15'h0000, t7}, 16'h0001);
      wb(1'b0, PBCC_ADDR_PIN, 16'h0000, 16'h0000);
      chk(q, 16'ha5a4);
      ext_en <= 16'h0000;
      wb(1'b1, PBCC_ADDR_DIR, 16'hfffc, 16'h0000);
      wb(1'b1, PBCC_ADDR_DATA, 16'h1234, 16'h0000);
      repeat (3) @(posedge clk_i);
      #1 chk(cap & PBCC_LINE_MASK, 16'h1234);
      $display("pin and capture tests done");
      wb(1'b1, PBCC_ADDR_CCSEL, 16'h0000, 16'h0000);
      wb(1'b1, PBCC_ADDR_DATA, 16'h0f00, 16'h0000);
      cmp(16'hfffc, 16'hfffc, 16'h0000);
      chk(pin_o & PBCC_LINE_MASK, 16'h00fc);
      cmp(16'h0000, 16'hfffc, 16'hfffc);
      chk(pin_o & PBCC_LINE_MASK, 16'h00fc);
      cmp(16'hfffc, 16'h0000, 16'hfffc);
      chk(pin_o & PBCC_LINE_MASK, 16'h00fc);
      wb(1'b1, PBCC_ADDR_CCSEL, 16'hfffc, 16'h0000);
      wb(1'b1, PBCC_ADDR_DATA, 16'h0000, 16'h0000);
      cmp(16'hfffc, 16'h0000, 16'hfffc);
      chk(pin_o & PBCC_LINE_MASK, 16'h0ffc);
      wb(1'b1, PBCC_ADDR_DATA, 16'h0000, 16'h0000);
      cmp(16'hfffc, 16'hfffc, 16'h0000);
      chk(pin_o & PBCC_LINE_MASK, 16'h0ffc);
      wb(1'b1, PBCC_ADDR_CCSEL, 16'h0000, 16'h0000);
      wb(1'b1, PBCC_ADDR_DATA, 16'h3c3c, 16'hfffc);
      repeat (2) @(posedge clk_i);
      #1 chk(pin_o & PBCC_LINE_MASK, 16'h3c3c);
      $display("compare tests done");
      wb(1'b1, PBCC_ADDR_ODRV, 16'hffff, 16'h0000);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1 chk(pin_oe, 16'h0000);
      wb(1'b0, PBCC_ADDR_ODRV, 16'h0000, 16'h0000);
      chk(q, PBCC_RST_REG);
      $display("mid-run reset done");
      conclude();
   end
endmodule : port2_capcom_pin_logic_tb_top
